// ==== design/timer_pair_defs.svh ====
// Constants for the dual 8-bit period timer block.
// Assumes a 32-bit APB with 18 address bits; index = byte address / 4.
`ifndef TIMER_PAIR_DEFS_SVH
`define TIMER_PAIR_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define APB_AW 18
`define IDX_W 16
`define CTRL_IDX 16'hFE3C
`define FIRST_PERIOD_IDX 16'hFE3E
`define SECOND_PERIOD_IDX 16'hFE3F
`define COUNT_IDX 16'hFE40
`define EVT_STATUS_IDX 16'hFE41
`define EVT_MASK_IDX 16'hFE42

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CTRL_RST 8'h00
`define PERIOD_RST 8'h00
`define EVT_RST 2'h0

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define FIRST_OVF_BIT 1
`define SECOND_OVF_BIT 3

// ----------------------------------------------------------------
// Prescaler terminal counts (interval minus one)
// ----------------------------------------------------------------
`define PRE_LIM_4 6'h03
`define PRE_LIM_16 6'h0F
`define PRE_LIM_64 6'h3F

`endif

// ==== design/timer_pair_pkg.sv ====
// Types for the dual 8-bit period timer block.
// Assumes timer_pair_defs.svh for the numeric constants.
package timer_pair_pkg;

  // Clock select codes
  typedef enum logic [1:0] {
    SEL_STOP,
    SEL_DIV4,
    SEL_DIV16,
    SEL_DIV64
  } clock_sel_e;

  // Control register layout, bit 7 down to bit 0
  typedef struct packed {
    clock_sel_e second_sel;
    clock_sel_e first_sel;
    logic second_overflow_flag;
    logic second_irq_enable;
    logic first_overflow_flag;
    logic first_irq_enable;
  } timer_ctrl_s;

  // APB request as seen by the slave
  typedef struct packed {
    logic [17:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_s;

endpackage

// ==== design/dual_8bit_period_timers.sv ====
// Dual 8-bit period timers with 6-bit prescalers behind an APB slave.
// Assumes one clock ref_clk and a synchronous active-low reset.
//
// Function
// RQ1 - Two independent 8-bit timers, each with its own 6-bit prescaler.
// RQ2 - Period is (period register + 1) times 4, 16 or 64 cycles.
// RQ3 - Interrupt request while any overflow flag and its enable are set.
// RQ4 - First counter steps per prescaler tick, wraps after period, sets flag.
// RQ5 - Second counter steps per prescaler tick, wraps after period, sets flag.
// RQ6 - First select bits 5:4 zero hold first prescaler and counter at zero.
// RQ7 - Second select bits 7:6 zero hold second prescaler and counter at zero.
// RQ8 - Select 00 stop, 01 four, 10 sixteen, 11 sixty-four cycles.
// RQ9 - Writing first period while running clears its prescaler and counter.
// RQ10 - Writing second period while running clears its prescaler and counter.
// RQ11 - Control holds selects, second flag/enable, first flag/enable.
// RQ12 - Each timer has an 8-bit read/write period register, reset zero.
// RQ13 - Software clears overflow flags; hardware only sets them.
// RQ14 - Writing zero clears a flag; a same-cycle set wins.
`timescale 1ns/100ps
`default_nettype none
`include "timer_pair_defs.svh"

module dual_8bit_period_timers
  import timer_pair_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [17:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic timer_irq,
  output logic event_irq
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Prescaler terminal count for a select code
  function automatic logic [5:0] pre_limit(input clock_sel_e sel);
    logic [5:0] lim;
    lim = `PRE_LIM_4;
    case (sel)
      SEL_DIV4: lim = `PRE_LIM_4;
      SEL_DIV16: lim = `PRE_LIM_16;
      SEL_DIV64: lim = `PRE_LIM_64;
      default: lim = `PRE_LIM_4;
    endcase
    return lim;
  endfunction

  // Word index match on an aligned address
  function automatic logic hit(input logic [17:0] addr,
                               input logic [15:0] idx);
    return (addr[17:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  apb_req_s req;
  timer_ctrl_s ctrl_r;
  timer_ctrl_s ctrl_nxt;
  logic [7:0] period_r [2];
  logic [5:0] pre_r [2];
  logic [7:0] ctr_r [2];
  logic [1:0] evt_status_r;
  logic [1:0] evt_status_nxt;
  logic [1:0] evt_mask_r;
  logic [31:0] prdata_r;
  clock_sel_e sel [2];
  logic [1:0] run;
  logic [1:0] tick;
  logic [1:0] wrap;
  logic [1:0] per_wr;
  logic mapped;
  logic access;
  logic wr_en;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic [31:0] rd_mux;

  assign req = '{paddr: paddr, psel: psel, penable: penable,
                 pwrite: pwrite, pwdata: pwdata};

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign mapped = hit(req.paddr, `CTRL_IDX)
                | hit(req.paddr, `FIRST_PERIOD_IDX)
                | hit(req.paddr, `SECOND_PERIOD_IDX)
                | hit(req.paddr, `COUNT_IDX)
                | hit(req.paddr, `EVT_STATUS_IDX)
                | hit(req.paddr, `EVT_MASK_IDX);

  // Zero wait states
  assign pready = 1'b1;
  assign access = req.psel & req.penable;
  assign pslverr = access & ~mapped;
  assign wr_en = access & req.pwrite & mapped;

  assign wr_ctrl = wr_en & hit(req.paddr, `CTRL_IDX);
  assign wr_status = wr_en & hit(req.paddr, `EVT_STATUS_IDX);
  assign wr_mask = wr_en & hit(req.paddr, `EVT_MASK_IDX);
  assign per_wr[0] = wr_en & hit(req.paddr, `FIRST_PERIOD_IDX);
  assign per_wr[1] = wr_en & hit(req.paddr, `SECOND_PERIOD_IDX);

  // Read multiplexer; unmapped reads return zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(req.paddr, `CTRL_IDX)) begin
      rd_mux[7:0] = ctrl_r;
    end else if (hit(req.paddr, `FIRST_PERIOD_IDX)) begin
      rd_mux[7:0] = period_r[0];
    end else if (hit(req.paddr, `SECOND_PERIOD_IDX)) begin
      rd_mux[7:0] = period_r[1];
    end else if (hit(req.paddr, `COUNT_IDX)) begin
      rd_mux[15:0] = {ctr_r[1], ctr_r[0]};
    end else if (hit(req.paddr, `EVT_STATUS_IDX)) begin
      rd_mux[1:0] = evt_status_r;
    end else if (hit(req.paddr, `EVT_MASK_IDX)) begin
      rd_mux[1:0] = evt_mask_r;
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (req.psel & ~req.penable & ~req.pwrite) begin
      prdata_r <= rd_mux;
    end
  end

  assign prdata = prdata_r;

  // ----------------------------------------------------------------
  // Timer control decode
  // ----------------------------------------------------------------
  assign sel[0] = ctrl_r.first_sel; // RQ11
  assign sel[1] = ctrl_r.second_sel; // RQ11

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      run[i] = (sel[i] != SEL_STOP); // RQ6 RQ7 RQ8
      tick[i] = run[i] && (pre_r[i] == pre_limit(sel[i])); // RQ2 RQ8
      wrap[i] = tick[i] && (ctr_r[i] == period_r[i]) && !per_wr[i]; // RQ4 RQ5
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = timer_ctrl_s'(req.pwdata[7:0]); // RQ11
      // Flags only clear on a written zero
      ctrl_nxt.first_overflow_flag = ctrl_r.first_overflow_flag
        & req.pwdata[`FIRST_OVF_BIT]; // RQ14 RQ13
      ctrl_nxt.second_overflow_flag = ctrl_r.second_overflow_flag
        & req.pwdata[`SECOND_OVF_BIT]; // RQ14 RQ13
    end
    // Hardware set wins over the clear
    ctrl_nxt.first_overflow_flag = ctrl_nxt.first_overflow_flag
      | wrap[0]; // RQ4 RQ14
    ctrl_nxt.second_overflow_flag = ctrl_nxt.second_overflow_flag
      | wrap[1]; // RQ5 RQ14
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctrl_r <= timer_ctrl_s'(`CTRL_RST);
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Period registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      period_r[0] <= `PERIOD_RST; // RQ12
      period_r[1] <= `PERIOD_RST; // RQ12
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (per_wr[i]) begin
          period_r[i] <= req.pwdata[7:0]; // RQ12
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Prescalers, one per timer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pre_r[0] <= 6'h00;
      pre_r[1] <= 6'h00;
    end else begin
      for (int i = 0; i < 2; i++) begin // RQ1
        if (!run[i] || per_wr[i]) begin
          pre_r[i] <= 6'h00; // RQ6 RQ7 RQ9 RQ10
        end else if (tick[i]) begin
          pre_r[i] <= 6'h00; // RQ2
        end else begin
          pre_r[i] <= pre_r[i] + 6'h01; // RQ2
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Counters, one per timer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ctr_r[0] <= 8'h00;
      ctr_r[1] <= 8'h00;
    end else begin
      for (int i = 0; i < 2; i++) begin // RQ1
        if (!run[i] || per_wr[i]) begin
          ctr_r[i] <= 8'h00; // RQ6 RQ7 RQ9 RQ10
        end else if (wrap[i]) begin
          ctr_r[i] <= 8'h00; // RQ4 RQ5
        end else if (tick[i]) begin
          ctr_r[i] <= ctr_r[i] + 8'h01; // RQ4 RQ5
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Event status and mask
  // ----------------------------------------------------------------
  always_comb begin
    evt_status_nxt = evt_status_r;
    if (wr_status) begin
      evt_status_nxt = evt_status_r & ~req.pwdata[1:0];
    end
    // Set wins over write-one-to-clear
    evt_status_nxt = evt_status_nxt | wrap;
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      evt_status_r <= `EVT_RST;
    end else begin
      evt_status_r <= evt_status_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      evt_mask_r <= `EVT_RST;
    end else if (wr_mask) begin
      evt_mask_r <= req.pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt outputs
  // ----------------------------------------------------------------
  assign timer_irq = (ctrl_r.first_overflow_flag & ctrl_r.first_irq_enable)
    | (ctrl_r.second_overflow_flag & ctrl_r.second_irq_enable); // RQ3

  assign event_irq = |(evt_status_r & evt_mask_r);

endmodule // dual_8bit_period_timers

`default_nettype wire

// ==== testbench/timer_pair_asserts.sv ====
// Port assertions for the dual 8-bit period timer block.
// Assumes it is bound to dual_8bit_period_timers.
`timescale 1ns/100ps
`default_nettype none
`include "timer_pair_defs.svh"

module timer_pair_asserts (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [17:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_irq,
  input wire logic event_irq
);
  // ----
  // Decode helpers
  // ----
  logic acc;
  logic wr;
  logic map;
  logic [15:0] ix;
  assign ix = paddr[17:2];
  assign acc = psel && penable;
  assign wr = acc && pwrite;
  assign map = paddr[1:0] == 2'h0 && (ix == `CTRL_IDX ||
    ix == `FIRST_PERIOD_IDX || ix == `SECOND_PERIOD_IDX ||
    ix == `COUNT_IDX || ix == `EVT_STATUS_IDX || ix == `EVT_MASK_IDX);

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_rst_irq; $rose(resetn) |-> !timer_irq && !event_irq; endproperty
  a_rst_irq: assert property (p_rst_irq) else $error("irq after reset");
  property p_tfall;
    $fell(timer_irq) |-> $past(wr && map && ix == `CTRL_IDX);
  endproperty
  a_tfall: assert property (p_tfall) else $error("irq fell alone");
  property p_efall;
    $fell(event_irq) |->
      $past(wr && map && (ix == `EVT_STATUS_IDX || ix == `EVT_MASK_IDX));
  endproperty
  a_efall: assert property (p_efall) else $error("event fell alone");
  property p_err; acc |-> pslverr == !map; endproperty
  a_err: assert property (p_err) else $error("pslverr wrong");
  property p_urd; acc && !pwrite && !map |-> prdata == 32'h0; endproperty
  a_urd: assert property (p_urd) else $error("unmapped read data");
  property p_ie_off;
    wr && map && ix == `CTRL_IDX && !pwdata[2] && !pwdata[0] |=> !timer_irq;
  endproperty
  a_ie_off: assert property (p_ie_off) else $error("irq not gated");
  property p_mask_off;
    wr && map && ix == `EVT_MASK_IDX && pwdata[1:0] == 2'h0 |=> !event_irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("mask ignored");
endmodule // timer_pair_asserts

bind dual_8bit_period_timers timer_pair_asserts u_chk (.ref_clk, .resetn,
  .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
  .timer_irq, .event_irq);
`default_nettype wire

// ==== testbench/dual_8bit_period_timers_test.sv ====
// Self-checking bench for the dual 8-bit period timer block.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "timer_pair_defs.svh"

module dual_8bit_period_timers_test;
  import timer_pair_pkg::*;
  logic ref_clk, resetn, psel, penable, pwrite, pready, pslverr, er;
  logic timer_irq, event_irq;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int n_mismatch, checks, k, p, cv;
  localparam logic [17:0] adr [6] = '{{`CTRL_IDX, 2'h0},
    {`FIRST_PERIOD_IDX, 2'h0}, {`SECOND_PERIOD_IDX, 2'h0},
    {`COUNT_IDX, 2'h0}, {`EVT_STATUS_IDX, 2'h0}, {`EVT_MASK_IDX, 2'h0}};

  dual_8bit_period_timers u_dut (.ref_clk, .resetn, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .timer_irq,
    .event_irq);

  // ----
  // Bus and compare tasks
  // ----
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(logic [17:0] a, logic w, logic [31:0] d);
    @(posedge ref_clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic rdchk(string nm, logic [17:0] a, logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(nm, e, rd);
  endtask
  task automatic wait_irq(int e);
    for (k = 1; k < 600; k++) begin
      @(posedge ref_clk);
      #1;
      if (timer_irq === 1'b1) break;
    end
    chk("period", e, k);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----
  // Clock, watchdog and tests
  // ----
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    end_of_test();
  end
  initial begin
    {resetn, psel, penable, pwrite, paddr, pwdata} = '0;
    n_mismatch = 0;
    checks = 0;
    void'($urandom(15));
    repeat (10) @(posedge ref_clk);
    resetn <= 1'b1;
    foreach (adr[i]) rdchk("reset", adr[i], 32'h0);
    apb(18'h3F8F4, 1'b0, 32'h0);
    chk("unmapped err", 32'h1, er);
    chk("unmapped data", 32'h0, rd);
    for (int t = 0; t < 2; t++) begin
      p = $urandom_range(255);
      apb(adr[1 + t], 1'b1, p);
      rdchk("period rw", adr[1 + t], p);
    end
    for (int t = 0; t < 2; t++) begin
      for (int s = 1; s < 4; s++) begin
        apb(adr[0], 1'b1, 32'h0);
        rdchk("stopped count", adr[3], 32'h0);
        apb(adr[5], 1'b1, (s == 2) ? 0 : 3);
        p = 4 + $urandom_range(3);
        apb(adr[1 + t], 1'b1, p);
        cv = (s << (4 + 2 * t)) | (t ? 4 : 1);
        apb(adr[0], 1'b1, cv);
        if (s == 1) begin
          repeat (5) @(posedge ref_clk);
          apb(adr[1 + t], 1'b1, p);
        end
        wait_irq((p + 1) * (4 ** s));
        chk("event irq", s != 2, event_irq);
        rdchk("ctrl flag", adr[0], cv | (t ? 8 : 2));
        apb(adr[0], 1'b1, cv);
        chk("irq clear", 32'h0, timer_irq);
        apb(adr[4], 1'b1, 32'h3);
        chk("event clear", 32'h0, event_irq);
        // Count as of ten edges after the wrap
        rdchk("count", adr[3], (10 / 4 ** s) << (8 * t));
      end
    end
    end_of_test();
  end
endmodule // dual_8bit_period_timers_test
`default_nettype wire
